//--- design/cabc_top.sv
// Correlator accumulate and blanking control: card strobes, core
// read-modify-write sequencing, blanking timer and rate divider.
// Assumes core read data is valid within one slot of its start pulse.
// Behaviour
// - one card channel served every 720ns
// - address counter selects card and core group
// - top bits of eight channels shifted, added
// - snapshot bit added at eighth bit weight
// - eighth adder output to bit 24 or 8
// - blanking moves card bytes eight at once
// - write source: counters first 416, then knobs
// - word sent as 15 then 5 bits
// - sign bit starts one, toggles per word
// - blanking stops counting, clears stores afterwards
// - integrate active high except during blanking
// - half-cycle flag starts blanking through flops
// - blanking length 4 to 34ms, 2ms ticks
// - divide 10 KHz, align to 10s reference
// - 500ns reset pulse aligns rate divider
// - three-state phase counter forms card strobes
// - Johnson sequencer, sixteen states, one bit steps
// - two-bit decode gives sixteen channel selects
// - first-stage gating blocks illegal sequencer states
// - sequencer reset keeps it aligned
// - shift and strobe drives copy phase outputs
// - core starts every 1.5us, 24 of 30us
`timescale 1ns/100ps
`include "cabc_defs.svh"
module cabc_top import cabc_pkg::*; #(
	parameter int STEP_CYC = `CABC_STEP_NS / `CABC_CLK_NS
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Timing references
	input wire logic i_ref_10k,
	input wire logic i_ref_0p1,
	// Counter store cards
	input wire logic [25:0] i_top_bit_snapshot,
	input wire cabc_bytes_t i_card_bytes,
	output cabc_strobe_t o_strobe,
	output logic [15:0] o_chan_sel,
	output logic [4:0] o_card_sel,
	output logic o_integrate_active,
	output logic o_store_clear,
	// Knob settings
	input wire logic [19:0] i_knob_word,
	output logic [3:0] o_knob_index,
	// Core memory
	input wire logic [19:0] i_core_rdata,
	output cabc_core_t o_core,
	// Computer port
	input wire logic i_computer_word_load,
	input wire logic i_computer_half_select,
	input wire logic i_transfer_start,
	output logic [15:0] o_computer_word
);

	localparam int PH_CYC = `CABC_PHASE_CYC;
	localparam int SLOT_CYC = `CABC_SLOT_CYC;
	localparam int WIN_CYC = `CABC_WIN_CYC;

	function automatic logic [16:0] cabc_half_ticks(input logic [1:0] sel);
		case (sel)
			2'h0: return 17'h001F4;
			2'h1: return 17'h01388;
			default: return 17'h0C350;
		endcase
	endfunction

	// ==========================================================
	// Register file
	logic [5:0] ctrl_r;
	logic wr_pend_r;
	logic [11:0] wr_ofs_r;
	logic [31:0] hrdata_r;
	logic [31:0] stat_w;
	logic acc;
	assign acc = i_hsel & i_hready & i_htrans[1];
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = hrdata_r;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_pend_r <= 1'b0;
			wr_ofs_r <= 12'h000;
			hrdata_r <= 32'h0000_0000;
		end else begin
			wr_pend_r <= acc & i_hwrite;
			wr_ofs_r <= i_haddr[11:0];
			if (acc && !i_hwrite) begin
				if (i_haddr[11:0] == `CABC_CTRL_OFS) begin
					hrdata_r <= {26'h0, ctrl_r};
				end else if (i_haddr[11:0] == `CABC_STAT_OFS) begin
					hrdata_r <= stat_w;
				end else begin
					hrdata_r <= 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_r <= `CABC_CTRL_RST;
		end else if (wr_pend_r && wr_ofs_r == `CABC_CTRL_OFS) begin
			ctrl_r <= i_hwdata[5:0];
		end
	end

	// ==========================================================
	// Rate divider from the 10 KHz reference
	logic ref_10k_q, ref_0p1_q;
	logic [16:0] rate_divider_r, half_cnt_r;
	logic [4:0] sync_cnt_r;
	logic tick_10k, sync_hold, half_cycle_sync_flag_r;
	assign tick_10k = i_ref_10k & ~ref_10k_q;
	assign sync_hold = sync_cnt_r != 5'h00;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_10k_q <= 1'b0;
			ref_0p1_q <= 1'b0;
			sync_cnt_r <= 5'h00;
		end else begin
			ref_10k_q <= i_ref_10k;
			ref_0p1_q <= i_ref_0p1;
			if (i_ref_0p1 && !ref_0p1_q) begin
				sync_cnt_r <= 5'(`CABC_SYNC_CYC);
			end else if (sync_hold) begin
				sync_cnt_r <= sync_cnt_r - 5'h01;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rate_divider_r <= 17'h00000;
			half_cnt_r <= 17'h00000;
			half_cycle_sync_flag_r <= 1'b0;
		end else begin
			half_cycle_sync_flag_r <= 1'b0;
			if (sync_hold) begin
				rate_divider_r <= 17'h00000;
				half_cnt_r <= 17'h00000;
			end else if (tick_10k) begin
				if (rate_divider_r == 17'(`CABC_TEN_S_TICKS - 1)) begin
					rate_divider_r <= 17'h00000;
				end else begin
					rate_divider_r <= rate_divider_r + 17'h00001;
				end
				if (half_cnt_r >= cabc_half_ticks(ctrl_r[5:4]) - 17'h00001) begin
					half_cnt_r <= 17'h00000;
					half_cycle_sync_flag_r <= 1'b1;
				end else begin
					half_cnt_r <= half_cnt_r + 17'h00001;
				end
			end
		end
	end

	// ==========================================================
	// Blanking timer
	logic blank_state_flop_r, blank_line_drivers_r, blank_end;
	logic [16:0] step_cnt_r;
	logic [4:0] blank_ms_counter_r;
	logic dump_r, dump_done_r;
	assign blank_end = blank_line_drivers_r &&
		blank_ms_counter_r == 5'(ctrl_r[3:0] + `CABC_LEN_BASE);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			blank_state_flop_r <= 1'b0;
			blank_line_drivers_r <= 1'b0;
		end else begin
			// Flag only starts a blanking from idle, so a clash with blank_end ends the blanking
			if (half_cycle_sync_flag_r && !blank_state_flop_r) begin
				blank_state_flop_r <= 1'b1;
			end else if (blank_end) begin
				blank_state_flop_r <= 1'b0;
			end
			blank_line_drivers_r <= blank_state_flop_r;
		end
	end
	assign o_integrate_active = ~blank_line_drivers_r;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			step_cnt_r <= 17'h00000;
			blank_ms_counter_r <= 5'h00;
		end else if (!blank_line_drivers_r) begin
			step_cnt_r <= 17'h00000;
			blank_ms_counter_r <= 5'h00;
		end else if (step_cnt_r == 17'(STEP_CYC - 1)) begin
			step_cnt_r <= 17'h00000;
			blank_ms_counter_r <= blank_ms_counter_r + 5'h01;
		end else begin
			step_cnt_r <= step_cnt_r + 17'h00001;
		end
	end

	// ==========================================================
	// Phase counter and card strobes
	cabc_phase_t phase_counter_r;
	logic [3:0] ph_div_r;
	logic ph_tick, chan_step, blank_start;
	assign ph_tick = ph_div_r == 4'(PH_CYC - 1);
	assign chan_step = ph_tick && phase_counter_r == CABC_PH_C;
	assign blank_start = blank_state_flop_r & ~blank_line_drivers_r;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ph_div_r <= 4'h0;
			phase_counter_r <= CABC_PH_A;
		end else if (sync_hold) begin
			ph_div_r <= 4'h0;
			phase_counter_r <= CABC_PH_A;
		end else begin
			ph_div_r <= ph_tick ? 4'h0 : ph_div_r + 4'h1;
			if (ph_tick) begin
				case (phase_counter_r)
					CABC_PH_A: phase_counter_r <= CABC_PH_B;
					CABC_PH_B: phase_counter_r <= CABC_PH_C;
					default: phase_counter_r <= CABC_PH_A;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_strobe <= '0;
		end else begin
			o_strobe.card_reset <= ~phase_counter_r[1] & ~phase_counter_r[0];
			o_strobe.card_load <= ~phase_counter_r[1] & phase_counter_r[0];
			o_strobe.card_count <= phase_counter_r[1] & phase_counter_r[0] &
				~blank_line_drivers_r;
			o_strobe.shift_pulse_drive <= phase_counter_r[1];
			o_strobe.strobe_pulse_drive <= phase_counter_r[0];
		end
	end

	cabc_johnson u_johnson (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_step(chan_step),
		.i_sync(sync_hold),
		.o_state(stat_w[23:16]),
		.o_sel(o_chan_sel)
	);

	// ==========================================================
	// Core frame: load window, then sixteen read/write slots
	logic [10:0] frame_cnt_r;
	logic [6:0] slot_cyc_r;
	logic [3:0] slot_r;
	logic [5:0] integration_address_counter_r;
	logic [7:0] top_bit_holding_shift_r;
	logic [7:0][7:0] blank_temp_shift_r;
	logic in_win, frame_end, run, load_now, prep;
	logic [8:0] pos;
	logic [19:0] src, sum;
	assign in_win = frame_cnt_r < 11'(WIN_CYC);
	assign frame_end = !in_win && slot_r == 4'hF && slot_cyc_r == 7'(SLOT_CYC - 1);
	assign run = ~blank_line_drivers_r | dump_r;
	assign load_now = in_win && frame_cnt_r[4:0] == 5'h00 && frame_cnt_r[10:8] == 3'h0;
	assign prep = run && !in_win && !slot_r[0] && slot_cyc_r == 7'(SLOT_CYC - 1);
	assign pos = {integration_address_counter_r, slot_r[3:1]};
	assign o_card_sel = integration_address_counter_r[5:1];
	assign o_knob_index = pos[3:0];
	assign stat_w[15:0] = {3'h0, pos, 1'b0, o_store_clear, dump_r, o_integrate_active};
	assign stat_w[31:24] = 8'h00;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_cnt_r <= 11'h000;
			slot_cyc_r <= 7'h00;
			slot_r <= 4'h0;
		end else if (blank_start || frame_end) begin
			frame_cnt_r <= 11'h000;
			slot_cyc_r <= 7'h00;
			slot_r <= 4'h0;
		end else if (in_win) begin
			frame_cnt_r <= frame_cnt_r + 11'h001;
		end else if (slot_cyc_r == 7'(SLOT_CYC - 1)) begin
			slot_cyc_r <= 7'h00;
			slot_r <= slot_r + 4'h1;
		end else begin
			slot_cyc_r <= slot_cyc_r + 7'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			integration_address_counter_r <= 6'h00;
			dump_r <= 1'b0;
			dump_done_r <= 1'b0;
		end else if (blank_start) begin
			integration_address_counter_r <= 6'h00;
			dump_r <= 1'b1;
			dump_done_r <= 1'b0;
		end else if (!blank_line_drivers_r) begin
			dump_done_r <= 1'b0;
			if (dump_r) begin
				dump_r <= 1'b0;
				integration_address_counter_r <= 6'h00;
			end else if (frame_end) begin
				integration_address_counter_r <=
					(integration_address_counter_r == 6'(`CABC_INT_FRAMES - 1)) ?
					6'h00 : integration_address_counter_r + 6'h01;
			end
		end else if (frame_end && dump_r) begin
			if (integration_address_counter_r == 6'(`CABC_DUMP_FRAMES - 1)) begin
				dump_r <= 1'b0;
				dump_done_r <= 1'b1;
			end else begin
				integration_address_counter_r <= integration_address_counter_r + 6'h01;
			end
		end
	end
	// Stores clear only once their contents are in core
	assign o_store_clear = blank_line_drivers_r & dump_done_r;

	// Snapshot and byte gathering in the load window
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			top_bit_holding_shift_r <= 8'h00;
			blank_temp_shift_r <= '0;
		end else if (run && load_now) begin
			top_bit_holding_shift_r <= {i_top_bit_snapshot[o_card_sel],
				top_bit_holding_shift_r[7:1]};
			blank_temp_shift_r <= {i_card_bytes[o_card_sel],
				blank_temp_shift_r[7:1]};
		end else if (prep) begin
			top_bit_holding_shift_r <= top_bit_holding_shift_r >> 1;
			blank_temp_shift_r <= {8'h00, blank_temp_shift_r[7:1]};
		end
	end

	// Adder and write source
	always_comb begin
		if (dump_r) begin
			sum = i_core_rdata + {12'h000, blank_temp_shift_r[0]};
		end else begin
			sum = i_core_rdata + (20'(top_bit_holding_shift_r[0]) << `CABC_SNAP_BIT);
		end
		src = (pos < 9'(`CABC_CH_POS)) ? sum : i_knob_word;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_core <= '0;
		end else begin
			o_core.start <= run && !in_win && slot_cyc_r == 7'h00;
			o_core.write <= slot_r[0];
			o_core.addr <= pos;
			if (prep) begin
				o_core.wdata <= {5'h00, src};
				// Knob words go to core untouched while dumping, counter words take sum bit 7 at bit 8; otherwise bit 24 takes it
				if (!dump_r) begin
					o_core.wdata[`CABC_TOP_POS] <= sum[`CABC_SNAP_BIT];
				end else if (pos < 9'(`CABC_CH_POS)) begin
					o_core.wdata[`CABC_BLANK_POS] <= sum[`CABC_SNAP_BIT];
				end
			end
		end
	end

	// ==========================================================
	// Computer word register
	logic next_sign_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_computer_word <= 16'h0000;
			next_sign_r <= 1'b1;
		end else begin
			if (i_computer_word_load) begin
				o_computer_word[15] <= i_transfer_start | next_sign_r;
				o_computer_word[14:0] <= i_computer_half_select ?
					{10'h000, i_core_rdata[19:15]} : i_core_rdata[14:0];
				next_sign_r <= ~(i_transfer_start | next_sign_r);
			end else if (i_transfer_start) begin
				next_sign_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Checks
	logic [7:0] gap_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap_r <= 8'h00;
		end else begin
			gap_r <= o_core.start ? 8'h01 : ((gap_r == 8'hFF) ? gap_r : gap_r + 8'h01);
		end
	end

	a_start_spacing: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_core.start && o_core.write |-> gap_r == 8'h4B)
		else $error("write start not 75 cycles after read");
	a_blank_entry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		half_cycle_sync_flag_r && o_integrate_active && !blank_state_flop_r |=>
		##1 !o_integrate_active) else $error("blanking did not start");
	a_blank_exit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		blank_end && !half_cycle_sync_flag_r |=> ##1 o_integrate_active)
		else $error("blanking did not end");
	a_count_stop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!o_integrate_active |=> !o_strobe.card_count)
		else $error("counting during blanking");
	a_sync_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(i_ref_0p1) |=> sync_hold [*8])
		else $error("divider reset pulse too short");
	a_strobe_copy: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_strobe.shift_pulse_drive == $past(phase_counter_r[1]) &&
		o_strobe.strobe_pulse_drive == $past(phase_counter_r[0]))
		else $error("drive copies wrong");
	a_sign_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_computer_word_load && i_transfer_start |=> o_computer_word[15])
		else $error("first word sign not one");
	a_sign_toggle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_computer_word_load && !i_transfer_start ##1
		(!i_transfer_start) [*1] ##0 i_computer_word_load |=>
		o_computer_word[15] != $past(o_computer_word[15]))
		else $error("sign bit did not toggle");
	a_snap_weight: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		prep && !dump_r && pos < 9'h1A0 |=>
		o_core.wdata[19:0] == $past(i_core_rdata) +
		(20'($past(top_bit_holding_shift_r[0])) << 7))
		else $error("snapshot added at wrong weight");

endmodule

//--- design/cabc_defs.svh
// Offsets, field positions, reset values and timing counts for the
// correlator accumulate and blanking control. Pure definitions.
`ifndef CABC_DEFS_SVH
`define CABC_DEFS_SVH

// ==========================================================
// Register map
`define CABC_CTRL_OFS 12'h000
`define CABC_STAT_OFS 12'h004
`define CABC_LEN_LSB 0
`define CABC_RATE_LSB 4
`define CABC_CTRL_RST 6'h00

// ==========================================================
// Timing
`define CABC_CLK_NS 20
`define CABC_PHASE_NS 250
`define CABC_PHASE_CYC (`CABC_PHASE_NS / `CABC_CLK_NS)
`define CABC_SLOT_NS 1500
`define CABC_SLOT_CYC (`CABC_SLOT_NS / `CABC_CLK_NS)
`define CABC_WIN_NS 6000
`define CABC_WIN_CYC (`CABC_WIN_NS / `CABC_CLK_NS)
`define CABC_LOAD_GAP 32
`define CABC_SYNC_NS 500
`define CABC_SYNC_CYC ((`CABC_SYNC_NS + `CABC_CLK_NS - 1) / `CABC_CLK_NS)
`define CABC_STEP_NS 2000000
`define CABC_TEN_S_TICKS 100000

// ==========================================================
// Counts and positions
`define CABC_SLOTS 16
`define CABC_INT_FRAMES 52
`define CABC_DUMP_FRAMES 54
`define CABC_CH_POS 416
`define CABC_TOP_POS 24
`define CABC_BLANK_POS 8
`define CABC_SNAP_BIT 7
`define CABC_LEN_BASE 2

`endif

//--- design/cabc_pkg.sv
// Types shared by the accumulate and blanking control and its sequencer.
// Assumes cabc_defs.svh is compiled alongside.
package cabc_pkg;

	// ==========================================================
	// Phase counter, one bit changes from A to B and B to C, two from C to A
	typedef enum logic [1:0] {
		CABC_PH_A = 2'b00,
		CABC_PH_B = 2'b01,
		CABC_PH_C = 2'b11
	} cabc_phase_t;

	// ==========================================================
	// Card strobes
	typedef struct packed {
		logic card_reset;
		logic card_load;
		logic card_count;
		logic shift_pulse_drive;
		logic strobe_pulse_drive;
	} cabc_strobe_t;

	// Core request
	typedef struct packed {
		logic start;
		logic write;
		logic [8:0] addr;
		logic [24:0] wdata;
	} cabc_core_t;

	typedef logic [25:0][7:0] cabc_bytes_t;

endpackage

//--- design/cabc_johnson.sv
// Eight-bit Johnson channel sequencer with sixteen channel selects.
// Assumes step is a one-cycle enable and sync a level held over several cycles, both on the common clock.
`timescale 1ns/100ps
`include "cabc_defs.svh"
module cabc_johnson import cabc_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Control
	input wire logic i_step,
	input wire logic i_sync,
	// Outputs
	output logic [7:0] o_state,
	output logic [15:0] o_sel
);

	function automatic logic cabc_legal(input logic [7:0] q);
		logic [6:0] d;
		d = q[7:1] ^ q[6:0];
		return (d & (d - 7'h01)) == 7'h00;
	endfunction

	logic [7:0] johnson_sequencer_r;

	// ==========================================================
	// Sequencer
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			johnson_sequencer_r <= 8'h00;
		end else if (i_sync) begin
			johnson_sequencer_r <= 8'h00;
		end else if (i_step) begin
			// Illegal pattern falls back to all zero
			if (cabc_legal(johnson_sequencer_r)) begin
				johnson_sequencer_r <= {johnson_sequencer_r[6:0], ~johnson_sequencer_r[7]};
			end else begin
				johnson_sequencer_r <= 8'h00;
			end
		end
	end

	// Two-bit decode of each state
	always_comb begin
		o_sel[0] = ~johnson_sequencer_r[7] & ~johnson_sequencer_r[0];
		o_sel[8] = johnson_sequencer_r[7] & johnson_sequencer_r[0];
		for (int k = 1; k < 8; k++) begin
			o_sel[k] = johnson_sequencer_r[k - 1] & ~johnson_sequencer_r[k];
			o_sel[k + 8] = ~johnson_sequencer_r[k - 1] & johnson_sequencer_r[k];
		end
	end
	assign o_state = johnson_sequencer_r;

	a_johnson_legal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cabc_legal(johnson_sequencer_r)) else $error("sequencer left legal set");
	a_johnson_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$past(i_step) && !$past(i_sync) |->
		$countones(johnson_sequencer_r ^ $past(johnson_sequencer_r)) == 1)
		else $error("sequencer step changed more than one bit");
	a_sel_onehot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$onehot(o_sel)) else $error("channel select not one-hot");

endmodule

//--- testbench/cabc_core_model.sv
// Behavioural core memory answering the control block's start pulses.
// Assumes one request at a time and reads that finish within a slot.
`timescale 1ns/100ps
module cabc_core_model import cabc_pkg::*; #(
	parameter int LAT = 40
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Core request and read data
	input wire cabc_core_t i_core,
	output logic [19:0] o_rdata
);
	logic [19:0] mem [0:511];
	logic [19:0] last_r;
	logic [8:0] raddr_r;
	logic rd_r;
	int cnt_r;

	// ==========================================================
	// Storage, preset so the first sums are known
	initial begin
		for (int i = 0; i < 512; i++) begin
			mem[i] = 20'(i * 3);
		end
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_r <= 1'b0;
			cnt_r <= 0;
			raddr_r <= 9'h000;
			last_r <= 20'h00000;
		end else begin
			last_r <= o_rdata;
			cnt_r <= cnt_r + 1;
			if (i_core.start) begin
				rd_r <= !i_core.write;
				raddr_r <= i_core.addr;
				cnt_r <= 0;
				if (i_core.write) begin
					mem[i_core.addr] <= i_core.wdata[19:0];
				end
			end
		end
	end

	// Outside a valid read the lines wander, so stale data never passes
	assign o_rdata = (rd_r && cnt_r >= LAT) ? mem[raddr_r] : ~last_r;
endmodule

//--- testbench/tb.sv
// Self-checking bench for the accumulate and blanking control.
// Assumes a fast 10 KHz reference stand-in and a short 2 ms step.
`timescale 1ns/100ps
`include "cabc_defs.svh"
module tb import cabc_pkg::*; ;
	localparam int STEP = 40;
	int fail_count = 0;
	int num_checks = 0;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h00000000;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hready;
	logic ref10k = 1'b0;
	logic ref0p1 = 1'b0;
	logic load = 1'b0;
	logic half = 1'b0;
	logic tstart = 1'b0;
	logic [19:0] core_rdata;
	logic [15:0] chan_sel;
	logic [15:0] cword;
	logic integ;
	logic hresp;
	logic [4:0] card_sel;
	logic [3:0] knob_idx;
	logic sclr;
	cabc_strobe_t strobe;
	cabc_core_t core;

	always #10 clk = ~clk;
	// Sped-up reference keeps a half switching cycle short
	always @(posedge clk) ref10k <= ~ref10k;

	cabc_top #(.STEP_CYC(STEP)) u_cabc_top (
		.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_ref_10k(ref10k), .i_ref_0p1(ref0p1), .i_top_bit_snapshot(26'h3FFFFFF),
		.i_card_bytes({26{8'hA5}}), .o_strobe(strobe), .o_chan_sel(chan_sel),
		.o_card_sel(card_sel), .o_integrate_active(integ), .o_store_clear(sclr),
		.i_knob_word(20'h5A5A5), .o_knob_index(knob_idx), .i_core_rdata(core_rdata),
		.o_core(core), .i_computer_word_load(load), .i_computer_half_select(half),
		.i_transfer_start(tstart), .o_computer_word(cword));

	cabc_core_model u_cabc_core_model (.i_clk(clk), .i_rst_n(rst_n), .i_core(core),
		.o_rdata(core_rdata));

	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("integ", 32'h1, integ);
		chk("chan_sel", 32'h1, chan_sel);
		chk("strobe", 32'h0, strobe);
	endtask

	task automatic t_core();
		logic [8:0] a;
		logic [19:0] e;
		int n;
		for (n = 0; n < 3000 && !(core.start === 1'b1 && core.write === 1'b0); n++) begin
			@(posedge clk);
		end
		a = core.addr;
		e = 20'(a) * 20'h00003 + 20'h00080;
		for (n = 1; n < 200; n++) begin
			@(posedge clk);
			if (core.start === 1'b1) break;
		end
		chk("start gap", 75, n);
		chk("write", 32'h1, core.write);
		chk("addr", a, core.addr);
		chk("sum", e, core.wdata[19:0]);
		chk("bit24", e[7], core.wdata[24]);
		chk("card sel", 32'h0, card_sel);
		chk("knob index", a[3:0], knob_idx);
	endtask

	task automatic t_regs();
		logic [31:0] r;
		ahb(1'b0, `CABC_CTRL_OFS, 32'h0, r);
		chk("ctrl reset", 32'h0, r);
		ahb(1'b1, `CABC_CTRL_OFS, 32'h2A, r);
		ahb(1'b0, `CABC_CTRL_OFS, 32'h0, r);
		chk("ctrl", 32'h2A, r);
		ahb(1'b0, `CABC_STAT_OFS, 32'h0, r);
		chk("stat integ", 32'h1, r[0]);
		ahb(1'b0, 32'h10, 32'h0, r);
		chk("unmapped", 32'h0, r);
		chk("hresp", 32'h0, hresp);
	endtask

	task automatic t_seq();
		logic [15:0] seen;
		logic [4:0] hi;
		logic [4:0] lo;
		int bad;
		seen = 16'h0000;
		hi = 5'h00;
		lo = 5'h00;
		bad = 0;
		repeat (600) begin
			@(posedge clk);
			if (!$onehot(chan_sel)) bad++;
			seen |= chan_sel;
			hi |= strobe;
			lo |= ~strobe;
		end
		chk("onehot bad", 32'h0, bad);
		chk("sel seen", 32'hFFFF, seen);
		chk("strobe moves", 32'h3FF, {hi, lo});
	endtask

	task automatic t_comp();
		logic [15:0] e;
		e = 16'h0000;
		// Back-to-back loads, each word checked one cycle after its load
		for (int i = 0; i < 5; i++) begin
			load <= (i < 4);
			half <= i[0];
			tstart <= (i == 0);
			@(posedge clk);
			if (i > 0) chk("computer word", e, cword);
			e = i[0] ? {1'b0, 10'h000, core_rdata[19:15]} : {1'b1, core_rdata[14:0]};
		end
	endtask

	task automatic t_blank(input int k);
		logic [31:0] r;
		int n;
		ahb(1'b1, `CABC_CTRL_OFS, 32'(k), r);
		for (n = 0; n < 4000 && integ !== 1'b0; n++) @(posedge clk);
		chk("blank start", 32'h1, n < 4000);
		for (n = 0; n < 2000 && integ !== 1'b1; n++) @(posedge clk);
		chk("blank min", 32'h1, n >= (1 + k) * STEP);
		chk("blank max", 32'h1, n <= (3 + k) * STEP);
	endtask

	task automatic t_dump();
		logic [31:0] r;
		logic [8:0] a;
		logic [19:0] s;
		logic [19:0] e;
		int n;
		ahb(1'b1, `CABC_CTRL_OFS, 32'h0000000A, r);
		for (n = 0; n < 4000 && integ !== 1'b0; n++) @(posedge clk);
		// Skip a read start launched just before the frame restarts
		@(posedge clk);
		for (n = 0; n < 1000 && !(core.start === 1'b1 && core.write === 1'b0); n++) begin
			@(posedge clk);
		end
		a = core.addr;
		chk("dump addr", 32'h0, a);
		s = u_cabc_core_model.mem[a] + 20'h000A5;
		e = s;
		e[8] = s[7];
		for (n = 0; n < 200 && !(core.start === 1'b1 && core.write === 1'b1); n++) begin
			@(posedge clk);
		end
		chk("dump sum", e, core.wdata[19:0]);
		chk("dump integ", 32'h0, integ);
		chk("store clear", 32'h0, sclr);
	endtask

	task automatic t_div();
		int bad;
		bad = 0;
		ref0p1 <= 1'b1;
		repeat (4) @(posedge clk);
		repeat (20) begin
			@(posedge clk);
			if (chan_sel !== 16'h0001) bad++;
		end
		chk("held in sync", 32'h0, bad);
		ref0p1 <= 1'b0;
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (20) @(posedge clk);
		t_reset();
		rst_n <= 1'b1;
		@(posedge clk);
		t_core();
		t_regs();
		t_seq();
		t_comp();
		t_blank(0);
		t_blank(2);
		t_dump();
		t_div();
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_sim();
	end
endmodule
